// *** cad_pkg.sv ***
// Shared constants and types for the core address decoder.
// Assumes a 21-bit byte address from the processor core.
package cad_pkg;

  localparam int CAD_AW = 21;
  localparam int CAD_DW = 16;

  // ==========================================================
  // Address ranges
  localparam logic [20:0] CAD_BASE_LO = 21'h000000;
  localparam logic [20:0] CAD_BASE_HI = 21'h00DFFF;
  localparam logic [20:0] CAD_BOOT_HI = 21'h000FFF;
  localparam logic [20:0] CAD_LOWX_LO = 21'h001000;
  localparam logic [20:0] CAD_RAM_LO = 21'h00F000;
  localparam logic [20:0] CAD_RAM_HI = 21'h00F7FF;
  localparam logic [20:0] CAD_FLC_LO = 21'h00F880;
  localparam logic [20:0] CAD_FLC_HI = 21'h00F8FF;
  localparam logic [20:0] CAD_SHB_LO = 21'h00F900;
  localparam logic [20:0] CAD_SHB_HI = 21'h00F90A;
  localparam logic [20:0] CAD_BUI_LO = 21'h00F980;
  localparam logic [20:0] CAD_BUI_HI = 21'h00F98F;
  localparam logic [20:0] CAD_DMA_LO = 21'h00FA00;
  localparam logic [20:0] CAD_DMA_HI = 21'h00FA7F;
  localparam logic [20:0] CAD_IOX_LO = 21'h00FB00;
  localparam logic [20:0] CAD_IOX_HI = 21'h00FBFF;
  localparam logic [20:0] CAD_MOD_LO = 21'h00FC00;
  localparam logic [20:0] CAD_MOD_HI = 21'h00FFFF;
  localparam logic [20:0] CAD_HIB_LO = 21'h010000;
  localparam logic [20:0] CAD_HIB_HI = 21'h0FFFFF;
  localparam logic [20:0] CAD_EXP_LO = 21'h100000;
  localparam logic [20:0] CAD_EXP_HI = 21'h1FFFFF;
  localparam logic [20:0] CAD_FAST_HI = 21'h00FFFF;

  // Expansion memory offset mask, 1 Mbyte
  localparam logic [19:0] CAD_EXP_MASK = 20'hFFFFF;

  // Reset value of captured environment
  localparam logic [1:0] CAD_ENV_RST = 2'h0;

  // ==========================================================
  // Environments, variants, targets
  typedef enum logic [1:0] {
    CAD_ENV_INTERNAL_ROM,
    CAD_ENV_ON_BOARD_DEBUG,
    CAD_ENV_EMULATION_BOARD
  } cad_env_t;

  typedef enum logic {
    CAD_VAR_FLASH56K,
    CAD_VAR_BOOTROM
  } cad_var_t;

  typedef enum logic [3:0] {
    CAD_TGT_NONE,
    CAD_TGT_BASE_INT,
    CAD_TGT_BASE_EXT,
    CAD_TGT_RAM,
    CAD_TGT_FLASH_CTL,
    CAD_TGT_SHBIOS,
    CAD_TGT_BUS_IF,
    CAD_TGT_DMA,
    CAD_TGT_IO_EXP,
    CAD_TGT_MODULES,
    CAD_TGT_EXP_MEM
  } cad_tgt_t;

  // Register access kinds
  typedef enum logic [2:0] {
    CAD_ACC_RW,
    CAD_ACC_RO,
    CAD_ACC_WO,
    CAD_ACC_SPLIT,
    CAD_ACC_W1C
  } cad_acc_t;

endpackage

// *** cad_if.sv ***
// Core-to-target access channel of the address decoder.
// Assumes both ends share clk and one synchronous reset.
`timescale 1ns/100ps
interface cad_if;
  import cad_pkg::*;
  logic req;
  logic wr;
  logic word;
  logic [CAD_AW-1:0] addr;
  logic [CAD_DW-1:0] wdata;
  logic ack;
  logic [CAD_DW-1:0] rdata;
  logic reserved_hit;

  modport decoder (
    input req, wr, word, addr, wdata,
    output ack, rdata, reserved_hit
  );
  modport core (
    output req, wr, word, addr, wdata,
    input ack, rdata, reserved_hit
  );
endinterface

// *** cad_core_port.sv ***
// Core-side end: issues accesses to the decoder channel.
// Assumes one user request pulse at a time; waits for ack.
`timescale 1ns/100ps
module cad_core_port
  import cad_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // User request
  input wire logic usr_req_in,
  input wire logic usr_wr_in,
  input wire logic usr_word_in,
  input wire logic [CAD_AW-1:0] usr_addr_in,
  input wire logic [CAD_DW-1:0] usr_wdata_in,
  // User answer
  output logic usr_busy_out,
  output logic usr_done_out,
  output logic [CAD_DW-1:0] usr_rdata_out,
  output logic usr_reserved_out,
  // Channel
  cad_if.core bus
);

  logic req;
  logic wr;
  logic word;
  logic [CAD_AW-1:0] addr;
  logic [CAD_DW-1:0] wdata;

  assign bus.req = req;
  assign bus.wr = wr;
  assign bus.word = word;
  assign bus.addr = addr;
  assign bus.wdata = wdata;

  // ==========================================================
  // Request hold until ack
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      req <= 1'b0;
      wr <= 1'b0;
      word <= 1'b0;
      addr <= '0;
      wdata <= '0;
    end else if (req && bus.ack) begin
      req <= 1'b0;
    end else if (!req && usr_req_in) begin
      // Caller picks width per register width and access kind
      req <= 1'b1;
      wr <= usr_wr_in;
      word <= usr_word_in;
      addr <= usr_addr_in;
      wdata <= usr_wdata_in;
    end
  end

  // ==========================================================
  // Answer capture
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      usr_busy_out <= 1'b0;
      usr_done_out <= 1'b0;
      usr_rdata_out <= '0;
      usr_reserved_out <= 1'b0;
    end else begin
      usr_done_out <= req && bus.ack;
      usr_busy_out <= (req && !bus.ack) || (!req && usr_req_in);
      if (req && bus.ack) begin
        usr_rdata_out <= bus.rdata;
        usr_reserved_out <= bus.reserved_hit;
      end
    end
  end

endmodule

// *** cad_decoder.sv ***
// Core address decoder: routes each core access to one target.
// Assumes environment straps are stable while reset is held.
`timescale 1ns/100ps
// Function
// - One 2 Mbyte space for code and data
// - Low 64K data accesses flagged fast
// - Base memory internal or external by environment
// - Flash variant: 000000-00DFFF is base memory
// - 00F000-00F7FF selects system RAM
// - 00F880-00F8FF selects flash control block
// - 00F900-00F90A selects shared BIOS block
// - 00F980-00F98F selects bus interface unit
// - 00FA00-00FA7F selects DMA controller block
// - 00FB00-00FBFF selects I/O expansion window
// - 00FC00-00FFFF selects module registers
// - 010000-0FFFFF reserved, or external base memory
// - 100000-1FFFFF selects expansion memory, large package
// - Boot variant: 4K base, rest expansion
// - Boot variant expansion 1 Mbyte, aliased
// - Core avoids reserved addresses
// - Memories take byte and word accesses
// - Register width matches transaction width
// - No reads of write-only, writes of read-only
// - Write one clears bit, zero leaves; a hardware set in the same cycle wins
// - Split address: read one, write another
// - Reserved bits written zero, read undefined
module cad_decoder
  import cad_pkg::*;
#(
  parameter cad_var_t VARIANT = CAD_VAR_FLASH56K,
  parameter bit LARGE_PKG = 1'b1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Environment straps
  input wire logic [1:0] env_strap_in,
  // Target selects
  output cad_tgt_t target_out,
  output logic [CAD_AW-1:0] target_addr_out,
  output logic sel_valid_out,
  output logic sel_wr_out,
  output logic sel_word_out,
  output logic [CAD_DW-1:0] sel_wdata_out,
  output logic fast_data_out,
  // Target answer
  input wire logic [CAD_DW-1:0] tgt_rdata_in,
  // Register block bookkeeping
  output logic [CAD_DW-1:0] w1c_stat_out,
  output logic [CAD_DW-1:0] split_wr_reg_out,
  output cad_env_t env_out,
  // Hardware event set for the clear-on-one register
  input wire logic [CAD_DW-1:0] w1c_set_in,
  // Read-side value of split register
  input wire logic [CAD_DW-1:0] split_rd_val_in,
  // Channel
  cad_if.decoder bus
);

  logic [1:0] strap_s1;
  logic [1:0] strap_s2;
  logic env_taken;
  logic ack;
  logic [CAD_DW-1:0] rdata;
  logic reserved_hit;
  cad_tgt_t next_target;
  logic [CAD_AW-1:0] next_taddr;

  assign bus.ack = ack;
  assign bus.rdata = rdata;
  assign bus.reserved_hit = reserved_hit;

  function automatic logic in_rng(input logic [20:0] a, input logic [20:0] lo, input logic [20:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  // ==========================================================
  // Environment capture at reset release
  always_ff @(posedge clk_in) begin
    strap_s1 <= env_strap_in;
    strap_s2 <= strap_s1;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      env_taken <= 1'b0;
      env_out <= cad_env_t'(CAD_ENV_RST);
    end else if (!env_taken) begin
      env_taken <= 1'b1;
      case (strap_s2)
        2'h1: env_out <= CAD_ENV_ON_BOARD_DEBUG;
        2'h2: env_out <= CAD_ENV_EMULATION_BOARD;
        default: env_out <= CAD_ENV_INTERNAL_ROM;
      endcase
    end
  end

  // ==========================================================
  // Address decode
  always_comb begin
    logic ext_env;
    ext_env = (env_out == CAD_ENV_EMULATION_BOARD);
    next_target = CAD_TGT_NONE;
    next_taddr = bus.addr;
    if (in_rng(bus.addr, CAD_RAM_LO, CAD_RAM_HI)) begin
      next_target = CAD_TGT_RAM;
    end else if (in_rng(bus.addr, CAD_FLC_LO, CAD_FLC_HI)) begin
      next_target = CAD_TGT_FLASH_CTL;
    end else if (in_rng(bus.addr, CAD_SHB_LO, CAD_SHB_HI)) begin
      next_target = CAD_TGT_SHBIOS;
    end else if (in_rng(bus.addr, CAD_BUI_LO, CAD_BUI_HI)) begin
      next_target = CAD_TGT_BUS_IF;
    end else if (in_rng(bus.addr, CAD_DMA_LO, CAD_DMA_HI)) begin
      next_target = CAD_TGT_DMA;
    end else if (in_rng(bus.addr, CAD_IOX_LO, CAD_IOX_HI)) begin
      next_target = CAD_TGT_IO_EXP;
    end else if (in_rng(bus.addr, CAD_MOD_LO, CAD_MOD_HI)) begin
      next_target = CAD_TGT_MODULES;
    end else if (in_rng(bus.addr, CAD_EXP_LO, CAD_EXP_HI)) begin
      if (LARGE_PKG) begin
        next_target = CAD_TGT_EXP_MEM;
        next_taddr = {1'b0, bus.addr[19:0] & CAD_EXP_MASK};
      end
    end else if (VARIANT == CAD_VAR_BOOTROM) begin
      if (in_rng(bus.addr, CAD_BASE_LO, CAD_BOOT_HI)) begin
        next_target = ext_env ? CAD_TGT_BASE_EXT : CAD_TGT_BASE_INT;
      end else if (in_rng(bus.addr, CAD_LOWX_LO, CAD_BASE_HI) || in_rng(bus.addr, CAD_HIB_LO, CAD_HIB_HI)) begin
        if (LARGE_PKG) begin
          next_target = CAD_TGT_EXP_MEM;
          next_taddr = {1'b0, bus.addr[19:0] & CAD_EXP_MASK};
        end
      end
    end else begin
      if (in_rng(bus.addr, CAD_BASE_LO, CAD_BASE_HI)) begin
        next_target = ext_env ? CAD_TGT_BASE_EXT : CAD_TGT_BASE_INT;
      end else if (in_rng(bus.addr, CAD_HIB_LO, CAD_HIB_HI) && ext_env) begin
        next_target = CAD_TGT_BASE_EXT;
      end
    end
  end

  // ==========================================================
  // Target strobe, one cycle per request
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      target_out <= CAD_TGT_NONE;
      target_addr_out <= '0;
      sel_valid_out <= 1'b0;
      sel_wr_out <= 1'b0;
      sel_word_out <= 1'b0;
      sel_wdata_out <= '0;
      fast_data_out <= 1'b0;
    end else begin
      // Ack is registered, so skip the edge right after a take
      sel_valid_out <= bus.req && !ack && !sel_valid_out;
      if (bus.req && !ack && !sel_valid_out) begin
        target_out <= next_target;
        target_addr_out <= next_taddr;
        sel_wr_out <= bus.wr;
        sel_word_out <= bus.word;
        sel_wdata_out <= bus.wdata;
        fast_data_out <= (bus.addr <= CAD_FAST_HI);
      end
    end
  end

  // ==========================================================
  // Answer: one cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ack <= 1'b0;
      rdata <= '0;
      reserved_hit <= 1'b0;
    end else begin
      ack <= sel_valid_out;
      reserved_hit <= sel_valid_out && (target_out == CAD_TGT_NONE);
      if (sel_valid_out) begin
        if (target_out == CAD_TGT_NONE) begin
          rdata <= '0;
        end else if (target_out == CAD_TGT_SHBIOS && target_addr_out == CAD_SHB_LO) begin
          rdata <= w1c_stat_out;
        end else if (target_out == CAD_TGT_SHBIOS && target_addr_out == CAD_SHB_LO + 21'h2) begin
          rdata <= split_rd_val_in;
        end else begin
          rdata <= tgt_rdata_in;
        end
      end
    end
  end

  // ==========================================================
  // Example register conventions in the shared block
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      w1c_stat_out <= '0;
    end else if (sel_valid_out && sel_wr_out && target_out == CAD_TGT_SHBIOS && target_addr_out == CAD_SHB_LO) begin
      w1c_stat_out <= (w1c_stat_out & ~sel_wdata_out) | w1c_set_in;
    end else begin
      w1c_stat_out <= w1c_stat_out | w1c_set_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      split_wr_reg_out <= '0;
    end else if (sel_valid_out && sel_wr_out && target_out == CAD_TGT_SHBIOS
                 && target_addr_out == CAD_SHB_LO + 21'h2) begin
      split_wr_reg_out <= sel_wdata_out;
    end
  end

endmodule

// *** cad_monitor.sv ***
// Checker watching the channel between core port and decoder.
// Assumes the bench instantiates it beside the joining interface.
`timescale 1ns/100ps
module cad_monitor
  import cad_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Channel
  input wire logic req,
  input wire logic wr,
  input wire logic word,
  input wire logic [CAD_AW-1:0] addr,
  input wire logic [CAD_DW-1:0] wdata,
  input wire logic ack,
  input wire logic [CAD_DW-1:0] rdata,
  input wire logic reserved_hit
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // ==========================================================
  // Channel timing
  property p_ack_lat; $rose(req) |-> !ack ##1 !ack ##1 ack; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack not two cycles after take");
  property p_ack_pulse; ack |-> req ##1 (!ack && !req); endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a single pulse");
  property p_req_hold; req && !ack |=> req; endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped before ack");
  property p_rdata_hold; !ack |-> $stable(rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without ack");
  // ==========================================================
  // Decode results
  property p_gap; ack && addr inside {[21'h00E000:21'h00EFFF], [21'h00F800:21'h00F87F]} |-> reserved_hit; endproperty
  a_gap: assert property (p_gap) else $error("gap address hit a target");
  property p_ram; ack && addr inside {[21'h00F000:21'h00F7FF]} |-> !reserved_hit; endproperty
  a_ram: assert property (p_ram) else $error("system RAM access refused");
  property p_shb_edge; ack && addr inside {[21'h00F90B:21'h00F97F]} |-> reserved_hit; endproperty
  a_shb_edge: assert property (p_shb_edge) else $error("address past shared block hit");
  property p_exp; ack && addr >= 21'h100000 |-> !reserved_hit; endproperty
  a_exp: assert property (p_exp) else $error("expansion memory access refused");
  property p_rsv_rd; ack && reserved_hit && !wr |-> rdata == 16'h0000; endproperty
  a_rsv_rd: assert property (p_rsv_rd) else $error("reserved read data not zero");
  property p_hit_ack; reserved_hit |-> ack; endproperty
  a_hit_ack: assert property (p_hit_ack) else $error("reserved flag outside ack");
endmodule

// *** tb.sv ***
// Bench joining both decoder ends, flash and boot variants side by side.
// Assumes the package constants and a 10 MHz core clock.
`timescale 1ns/100ps
module tb;
  import cad_pkg::*;
  // ==========================================================
  // Signals
  typedef struct packed {logic [CAD_AW-1:0] a; cad_tgt_t t;} cad_row_t;
  localparam logic [CAD_DW-1:0] TGT_RD = 16'hA5C3;
  localparam logic [CAD_DW-1:0] SPLIT_RD = 16'hBEEF;
  localparam cad_row_t ROWS [23] = '{
    '{21'h000000, CAD_TGT_BASE_INT}, '{21'h00DFFF, CAD_TGT_BASE_INT}, '{21'h00E000, CAD_TGT_NONE},
    '{21'h00F000, CAD_TGT_RAM}, '{21'h00F7FF, CAD_TGT_RAM}, '{21'h00F800, CAD_TGT_NONE},
    '{21'h00F880, CAD_TGT_FLASH_CTL}, '{21'h00F8FF, CAD_TGT_FLASH_CTL}, '{21'h00F90A, CAD_TGT_SHBIOS},
    '{21'h00F90B, CAD_TGT_NONE}, '{21'h00F980, CAD_TGT_BUS_IF}, '{21'h00F98F, CAD_TGT_BUS_IF},
    '{21'h00F990, CAD_TGT_NONE}, '{21'h00FA00, CAD_TGT_DMA}, '{21'h00FA7F, CAD_TGT_DMA},
    '{21'h00FA80, CAD_TGT_NONE}, '{21'h00FB00, CAD_TGT_IO_EXP}, '{21'h00FBFF, CAD_TGT_IO_EXP},
    '{21'h00FC00, CAD_TGT_MODULES}, '{21'h00FFFF, CAD_TGT_MODULES}, '{21'h010000, CAD_TGT_NONE},
    '{21'h100000, CAD_TGT_EXP_MEM}, '{21'h1FFFFF, CAD_TGT_EXP_MEM}};
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic req = 1'b0;
  logic wr = 1'b0;
  logic word = 1'b0;
  logic [CAD_AW-1:0] addr = 21'h000000;
  logic [CAD_DW-1:0] wdata = 16'h0000;
  logic [1:0] strap = 2'h0;
  logic [CAD_DW-1:0] set_bits = 16'h0000;
  logic busy, done, rsv, fast, sel_wr, sel_word, sel_pulse;
  logic [CAD_DW-1:0] rdata, w1c, split, wd_seen;
  logic [CAD_AW-1:0] taddr, b_taddr;
  cad_tgt_t tgt, b_tgt;
  cad_env_t env;
  int miscompares = 0;
  int samples_checked = 0;
  always #50 clk_in = ~clk_in;
  cad_if bus_a();
  cad_if bus_b();
  cad_core_port cad_core_port_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .usr_req_in(req), .usr_wr_in(wr),
    .usr_word_in(word), .usr_addr_in(addr), .usr_wdata_in(wdata), .usr_busy_out(busy), .usr_done_out(done),
    .usr_rdata_out(rdata), .usr_reserved_out(rsv), .bus(bus_a));
  cad_decoder cad_decoder_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .env_strap_in(strap), .target_out(tgt),
    .target_addr_out(taddr), .sel_valid_out(sel_pulse), .sel_wr_out(sel_wr), .sel_word_out(sel_word),
    .sel_wdata_out(wd_seen), .fast_data_out(fast), .tgt_rdata_in(TGT_RD), .w1c_stat_out(w1c),
    .split_wr_reg_out(split), .env_out(env), .w1c_set_in(set_bits), .split_rd_val_in(SPLIT_RD), .bus(bus_a));
  cad_core_port boot_cad_core_port_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .usr_req_in(req), .usr_wr_in(wr),
    .usr_word_in(word), .usr_addr_in(addr), .usr_wdata_in(wdata), .usr_busy_out(), .usr_done_out(),
    .usr_rdata_out(), .usr_reserved_out(), .bus(bus_b));
  cad_decoder #(.VARIANT(CAD_VAR_BOOTROM), .LARGE_PKG(1'b1)) boot_cad_decoder_inst (.clk_in(clk_in),
    .rst_b_in(rst_b_in), .env_strap_in(strap), .target_out(b_tgt), .target_addr_out(b_taddr), .sel_valid_out(),
    .sel_wr_out(), .sel_word_out(), .sel_wdata_out(), .fast_data_out(), .tgt_rdata_in(TGT_RD), .w1c_stat_out(),
    .split_wr_reg_out(), .env_out(), .w1c_set_in(set_bits), .split_rd_val_in(SPLIT_RD), .bus(bus_b));
  cad_monitor cad_monitor_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .req(bus_a.req), .wr(bus_a.wr),
    .word(bus_a.word), .addr(bus_a.addr), .wdata(bus_a.wdata), .ack(bus_a.ack), .rdata(bus_a.rdata),
    .reserved_hit(bus_a.reserved_hit));
  // ==========================================================
  // Tasks
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [40:0] seen, input logic [40:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step();
    @(posedge clk_in);
    #1;
  endtask
  task automatic access(input logic [CAD_AW-1:0] a, input logic w, input logic wd, input logic [CAD_DW-1:0] d);
    int n;
    int pulses;
    addr = a;
    wr = w;
    word = wd;
    wdata = d;
    req = 1'b1;
    step();
    req = 1'b0;
    n = 0;
    pulses = 0;
    while (done !== 1'b1 && n < 20) begin
      step();
      n++;
      if (sel_pulse === 1'b1) pulses++;
    end
    if (n == 20) begin
      miscompares++;
      give_verdict();
    end
    check(pulses, 1);
  endtask
  task automatic do_reset(input logic [1:0] s);
    rst_b_in = 1'b0;
    strap = s;
    repeat (20) step();
    check({tgt, w1c, split, busy, done, rsv}, 41'h0);
    rst_b_in = 1'b1;
    repeat (2) step();
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    do_reset(2'h0);
    for (int i = 0; i < 23; i++) begin
      access(ROWS[i].a, i[0], ~ROWS[i].a[0], ROWS[i].a[15:0]);
      check(fast, ROWS[i].a <= CAD_FAST_HI);
      if (ROWS[i].t == CAD_TGT_NONE) check({rsv, rdata}, {1'b1, 16'h0000});
      else if (i[0]) check({tgt, sel_wr, sel_word, wd_seen}, {ROWS[i].t, 2'b11 ^ ROWS[i].a[0], ROWS[i].a[15:0]});
      else check({rsv, tgt, rdata}, {1'b0, ROWS[i].t, TGT_RD});
      if (ROWS[i].t == CAD_TGT_EXP_MEM) check(taddr, {1'b0, ROWS[i].a[19:0]});
    end
    $display("test table done");
    access(21'h000FFF, 1'b0, 1'b0, 16'h0000);
    check(b_tgt, CAD_TGT_BASE_INT);
    access(21'h001000, 1'b0, 1'b1, 16'h0000);
    check({b_tgt, b_taddr}, {CAD_TGT_EXP_MEM, 21'h001000});
    access(21'h110000, 1'b1, 1'b1, 16'h5A5A);
    check({b_tgt, b_taddr}, {CAD_TGT_EXP_MEM, 21'h010000});
    $display("test boot done");
    set_bits = 16'h00FF;
    repeat (2) step();
    set_bits = 16'h0000;
    step();
    check(w1c, 16'h00FF);
    access(21'h00F900, 1'b1, 1'b1, 16'h000F);
    check(w1c, 16'h00F0);
    access(21'h00F900, 1'b1, 1'b1, 16'h0000);
    check(w1c, 16'h00F0);
    set_bits = 16'h0001;
    access(21'h00F900, 1'b1, 1'b1, 16'h0001);
    set_bits = 16'h0000;
    check(w1c, 16'h00F1);
    access(21'h00F902, 1'b1, 1'b1, 16'h1234);
    access(21'h00F902, 1'b0, 1'b1, 16'h0000);
    check({split, rdata}, {16'h1234, SPLIT_RD});
    $display("test registers done");
    for (int s = 0; s < 4; s++) begin
      do_reset(s[1:0]);
      check(env, s == 2 ? CAD_ENV_EMULATION_BOARD : s == 1 ? CAD_ENV_ON_BOARD_DEBUG : CAD_ENV_INTERNAL_ROM);
      access(21'h000000, 1'b0, 1'b1, 16'h0000);
      check(tgt, s == 2 ? CAD_TGT_BASE_EXT : CAD_TGT_BASE_INT);
      access(21'h0ABCDE, 1'b1, 1'b1, 16'h1234);
      check(rsv, s != 2);
    end
    $display("test environments done");
    give_verdict();
  end
endmodule
